// ---- verilog/prpd_pkg.sv ----
/*
 * Shared constants and carrier types of the peer-delay capture register group.
 * Assumes a 32-bit APB register port and one clock for the whole group.
 */
`default_nettype none
package prpd_pkg;
	localparam logic [11:0] PRPD_OFF_SEC     = 12'h178;
	localparam logic [11:0] PRPD_OFF_NS      = 12'h17c;
	localparam logic [11:0] PRPD_OFF_CF_HI   = 12'h180;
	localparam logic [11:0] PRPD_OFF_CF_LO   = 12'h184;
	localparam logic [11:0] PRPD_OFF_UDP_CNT = 12'h188;
	localparam logic [11:0] PRPD_OFF_FLT_CNT = 12'h18c;
	localparam logic [11:0] PRPD_OFF_IRQ_STS = 12'h190;
	localparam logic [11:0] PRPD_OFF_IRQ_MSK = 12'h194;
	localparam logic [2:0]  PRPD_BANK_PORT   = 3'h1;
	localparam int          PRPD_AUTO_BIT    = 31;
	localparam int          PRPD_SEC_W       = 4;
	localparam int          PRPD_NS_W        = 30;
	localparam int          PRPD_CF_W        = 48;
	localparam int          PRPD_CF_FRAC_W   = 16;
	localparam int          PRPD_CNT_W       = 32;
	localparam int          PRPD_IRQ_W       = 4;
	localparam logic [31:0] PRPD_CNT_MAX     = 32'hffffffff;
	localparam logic [31:0] PRPD_ZERO        = 32'h00000000;

	typedef struct packed {
		logic        valid;
		logic [3:0]  seconds_stamp;
		logic [29:0] nanosecond_stamp;
		logic [63:0] residence_correction;
	} prpd_capture_t;

	typedef struct packed {
		logic        udp_bad;
		logic        filtered;
	} prpd_drop_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} prpd_apb_req_t;
endpackage : prpd_pkg
`default_nettype wire

// ---- verilog/prpd_sat_counter.sv ----
/*
 * One saturating 32-bit drop tally with a clear-by-zero-write port.
 * Assumes the caller decodes the zero write into a one-cycle clear pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module prpd_sat_counter (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        inc,
	input  wire logic        clr,
	output logic [31:0]      count
);
	import prpd_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
	} prpd_cnt_state_t;

	prpd_cnt_state_t st_reg;
	prpd_cnt_state_t st_next;

	// Clear wins here; a hit in the clear cycle is dropped, which is allowed.
	always_comb begin
		st_next = st_reg;
		if (clr) begin
			st_next.cnt = PRPD_ZERO;
		end else if (inc && st_reg.cnt != PRPD_CNT_MAX) begin
			st_next.cnt = st_reg.cnt + 32'h00000001;
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign count = st_reg.cnt;
endmodule : prpd_sat_counter // prpd_sat_counter
`default_nettype wire

// ---- verilog/prpd_drop_events.sv ----
/*
 * Drop-event front end: counts both drop causes and flags a MAC error.
 * Assumes drop strobes are one-cycle pulses from parser and filter.
 */
`timescale 1ns/1ps
`default_nettype none
module prpd_drop_events (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire prpd_pkg::prpd_drop_t drop,
	input  wire logic        clr_udp,
	input  wire logic        clr_flt,
	output logic [31:0]      udp_error_drop_tally,
	output logic [31:0]      filter_drop_tally,
	output logic             mac_rx_error
);
	import prpd_pkg::*;

	typedef struct packed {
		logic err;
	} prpd_ev_state_t;

	prpd_ev_state_t st_reg;
	prpd_ev_state_t st_next;

	// Bad-checksum drops.
	prpd_sat_counter u_udp_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.inc     (drop.udp_bad),
		.clr     (clr_udp),
		.count   (udp_error_drop_tally)
	);

	// Filter discards, kept apart from checksum drops.
	prpd_sat_counter u_flt_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.inc     (drop.filtered),
		.clr     (clr_flt),
		.count   (filter_drop_tally)
	);

	// Either drop cause is also a receive error at the MAC.
	always_comb begin
		st_next = st_reg;
		st_next.err = drop.udp_bad | drop.filtered;
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign mac_rx_error = st_reg.err;
endmodule : prpd_drop_events // prpd_drop_events
`default_nettype wire

// ---- verilog/prpd_regs.sv ----
/*
 * Per-port receive peer-delay capture registers with drop tallies, APB slave
 * and interrupt. Assumes the bank select is decoded outside and presented as
 * a three-bit field; the ingress timestamp unit delivers one-cycle captures.
 */
`timescale 1ns/1ps
`default_nettype none
module prpd_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic [2:0]  bank_sel,
	input  wire logic        ts_enable,
	input  wire prpd_pkg::prpd_capture_t capture,
	input  wire prpd_pkg::prpd_drop_t    drop,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             mac_rx_error,
	output logic             irq
);
	import prpd_pkg::*;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_SEC, SEL_NS, SEL_CF_HI, SEL_CF_LO,
		SEL_UDP, SEL_FLT, SEL_STS, SEL_MSK
	} prpd_sel_t;

	typedef struct packed {
		logic                  auto_upd;
		logic [PRPD_SEC_W-1:0] sec;
		logic [PRPD_NS_W-1:0]  ns;
		logic [PRPD_CF_W-1:0]  cf;
		logic [PRPD_IRQ_W-1:0] sts;
		logic [PRPD_IRQ_W-1:0] msk;
		logic [31:0]           rdata;
		logic                  ready;
		logic                  err;
		logic                  irq;
	} prpd_state_t;

	prpd_state_t st_reg;
	prpd_state_t st_next;

	logic [31:0] udp_cnt;
	logic [31:0] flt_cnt;
	logic        mac_err;
	logic        clr_udp;
	logic        clr_flt;

	// Address decode, shared by the write path and the read mux.
	function automatic prpd_sel_t prpd_decode(input logic [11:0] a,
			input logic [2:0] b);
		prpd_sel_t s;
		s = SEL_NONE;
		if (b == PRPD_BANK_PORT) begin
			unique case (a)
				PRPD_OFF_SEC:     s = SEL_SEC;
				PRPD_OFF_NS:      s = SEL_NS;
				PRPD_OFF_CF_HI:   s = SEL_CF_HI;
				PRPD_OFF_CF_LO:   s = SEL_CF_LO;
				PRPD_OFF_UDP_CNT: s = SEL_UDP;
				PRPD_OFF_FLT_CNT: s = SEL_FLT;
				PRPD_OFF_IRQ_STS: s = SEL_STS;
				PRPD_OFF_IRQ_MSK: s = SEL_MSK;
				default:          s = SEL_NONE;
			endcase
		end
		return s;
	endfunction

	// Byte-lane merge so partial APB writes to stamp and correction registers only touch enabled lanes; a tally clears when its merged word is zero.
	function automatic logic [31:0] prpd_merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	prpd_sel_t sel;
	logic      acc;
	logic      wr;
	logic [31:0] wd_udp;
	logic [31:0] wd_flt;

	assign sel     = prpd_decode(paddr, bank_sel);
	assign acc     = psel & penable & ~st_reg.ready;
	assign wr      = acc & pwrite;
	assign wd_udp  = prpd_merge(udp_cnt, pwdata, pstrb);
	assign wd_flt  = prpd_merge(flt_cnt, pwdata, pstrb);
	assign clr_udp = wr && sel == SEL_UDP && wd_udp == PRPD_ZERO;
	assign clr_flt = wr && sel == SEL_FLT && wd_flt == PRPD_ZERO;

	// Drop tallies and the MAC error strobe.
	prpd_drop_events u_drop (
		.pclk                 (pclk),
		.presetn              (presetn),
		.drop                 (drop),
		.clr_udp              (clr_udp),
		.clr_flt              (clr_flt),
		.udp_error_drop_tally (udp_cnt),
		.filter_drop_tally    (flt_cnt),
		.mac_rx_error         (mac_err)
	);

	// Registered bus answer: one wait state, then pready for one cycle.
	// Hardware capture is applied after the software write so that a request
	// landing in the same cycle as a store is never lost.
	always_comb begin
		logic [31:0] w;
		logic [PRPD_IRQ_W-1:0] ev;
		w = 32'h00000000;
		ev = '0;
		st_next = st_reg;
		st_next.ready = acc;
		st_next.err = acc & (sel == SEL_NONE);
		st_next.rdata = 32'h00000000;
		if (wr) begin
			unique case (sel)
				SEL_SEC: begin
					w = prpd_merge({28'h0000000, st_reg.sec}, pwdata, pstrb);
					st_next.sec = w[PRPD_SEC_W-1:0];
				end
				SEL_NS: begin
					w = prpd_merge({st_reg.auto_upd, 1'b0, st_reg.ns},
						pwdata, pstrb);
					st_next.ns = w[PRPD_NS_W-1:0];
					// Changing the mode while enabled is ignored.
					if (!ts_enable) begin
						st_next.auto_upd = w[PRPD_AUTO_BIT];
					end
				end
				SEL_CF_HI: begin
					w = prpd_merge(st_reg.cf[47:16], pwdata, pstrb);
					st_next.cf[47:16] = w;
				end
				SEL_CF_LO: begin
					w = prpd_merge({st_reg.cf[15:0], 16'h0000}, pwdata, pstrb);
					st_next.cf[15:0] = w[31:16];
				end
				SEL_STS: begin
					st_next.sts = st_reg.sts & ~pwdata[PRPD_IRQ_W-1:0];
				end
				SEL_MSK: begin
					st_next.msk = pwdata[PRPD_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// Capture only in auto mode; otherwise software keeps the fields.
		if (capture.valid && st_reg.auto_upd) begin
			st_next.sec = capture.seconds_stamp;
			st_next.ns  = capture.nanosecond_stamp;
			// The low 16 bits are the sub-nanosecond fraction.
			st_next.cf  = capture.residence_correction[63:PRPD_CF_FRAC_W];
		end
		if (acc && !pwrite) begin
			unique case (sel)
				SEL_SEC:   st_next.rdata = {28'h0000000, st_reg.sec};
				SEL_NS:    st_next.rdata = {st_reg.auto_upd, 1'b0, st_reg.ns};
				SEL_CF_HI: st_next.rdata = st_reg.cf[47:16];
				SEL_CF_LO: st_next.rdata = {st_reg.cf[15:0], 16'h0000};
				SEL_UDP:   st_next.rdata = udp_cnt;
				SEL_FLT:   st_next.rdata = flt_cnt;
				SEL_STS:   st_next.rdata = {28'h0000000, st_reg.sts};
				SEL_MSK:   st_next.rdata = {28'h0000000, st_reg.msk};
				default:   st_next.rdata = 32'h00000000;
			endcase
		end
		// Events: capture, checksum drop, filter drop, tally saturation.
		ev[0] = capture.valid & st_reg.auto_upd;
		ev[1] = drop.udp_bad;
		ev[2] = drop.filtered;
		ev[3] = (udp_cnt == PRPD_CNT_MAX) | (flt_cnt == PRPD_CNT_MAX);
		// Set wins over a write-one clear in the same cycle.
		st_next.sts = st_next.sts | ev;
		st_next.irq = |(st_next.sts & st_next.msk);
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata       = st_reg.rdata;
	assign pready       = st_reg.ready;
	assign pslverr      = st_reg.err;
	assign mac_rx_error = mac_err;
	assign irq          = st_reg.irq;
endmodule : prpd_regs // prpd_regs
`default_nettype wire

// ---- test/prpd_regs_assertions.sv ----
/*
 * Checker for answer timing, refusals, drop errors and interrupt causes.
 * Assumes it is bound to prpd_regs and sees that module's ports only.
 */
`timescale 1ns/1ps
`default_nettype none
module prpd_regs_assertions
	import prpd_pkg::*;
(
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [2:0]          bank_sel,
	input wire prpd_capture_t       capture,
	input wire prpd_drop_t          drop,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic                mac_rx_error,
	input wire logic                irq
);
	// Every check samples the bus clock and rests while reset is low.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("answer did not follow the access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready stood longer than one cycle");
	chk_bank_refuse: assert property (
		psel && penable && !pready && bank_sel != PRPD_BANK_PORT
		|=> pslverr && prdata == PRPD_ZERO)
		else $error("foreign bank access not refused");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error answer without ready");
	chk_rdata_idle: assert property (!pready |-> prdata == PRPD_ZERO)
		else $error("read data outside the answer cycle");
	chk_drop_err: assert property (
		drop.udp_bad || drop.filtered |=> mac_rx_error)
		else $error("drop not reported to the receiver");
	chk_err_cause: assert property (
		mac_rx_error |-> $past(drop.udp_bad || drop.filtered))
		else $error("receive error without a drop");
	// Interrupt may only move after a completed access or a new event.
	chk_irq_cause: assert property ($changed(irq) |->
		$past((psel && penable) || capture.valid || drop.udp_bad ||
		drop.filtered))
		else $error("interrupt moved without a cause");
endmodule // prpd_regs_assertions

bind prpd_regs prpd_regs_assertions chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .bank_sel(bank_sel),
	.capture(capture), .drop(drop), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .mac_rx_error(mac_rx_error), .irq(irq));
`default_nettype wire

// ---- test/tb_prpd_regs.sv ----
/*
 * Self-checking bench for the peer-delay capture registers and tallies.
 * Assumes the design answers APB in its own time and one 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_prpd_regs;
	import prpd_pkg::*;
	typedef struct { logic [11:0] a; logic [31:0] w; logic [31:0] x; } prpd_row_t;
	logic          pclk = 0;
	logic          presetn = 0;
	logic          psel = 0;
	logic          penable = 0;
	logic          pwrite = 0;
	logic          ts_enable = 0;
	logic          pready, pslverr, mac_rx_error, irq, er;
	logic [11:0]   paddr = '0;
	logic [31:0]   pwdata = '0;
	logic [31:0]   prdata, rd;
	logic [2:0]    bank_sel = 3'h1;
	prpd_capture_t cap = '0;
	prpd_drop_t    drop = '0;
	int            n_mismatch = 0;
	int            tests_run = 0;
	prpd_row_t     rows[4] = '{'{PRPD_OFF_SEC, 32'hffffffff, 32'h0000000f},
		'{PRPD_OFF_NS, 32'h7fffffff, 32'h3fffffff},
		'{PRPD_OFF_CF_HI, 32'hffffffff, 32'hffffffff},
		'{PRPD_OFF_CF_LO, 32'hffffffff, 32'hffff0000}};

	// Free-running bus clock, 5 ns period.
	always #2.5 pclk = ~pclk;

	prpd_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .bank_sel(bank_sel), .ts_enable(ts_enable),
		.capture(cap), .drop(drop), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mac_rx_error(mac_rx_error), .irq(irq));

	task automatic summarize();
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, g, x);
		end
	endtask

	task automatic chk1(input logic g, input logic x);
		chk({31'h0, g}, {31'h0, x});
	endtask

	// One APB transfer; the request is held until ready is seen high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 50) begin
			n_mismatch++;
			summarize();
		end
	endtask

	// Offers one peer-delay capture pulse.
	task automatic capt();
		@(posedge pclk);
		cap <= '{1'b1, 4'ha, 30'h12345678, 64'h0123456789abcdef};
		@(posedge pclk);
		cap.valid <= 0;
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 8; i++) begin
			apb(0, PRPD_OFF_SEC + 12'(4 * i), 0);
			chk(rd, PRPD_ZERO);
		end
		$display("test reset_values done");
		// Table rows: write all ones (bit 31 of the NS row stays clear), read back only the writable fields.
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].w);
			apb(0, rows[i].a, 0);
			chk(rd, rows[i].x);
			chk1(er, 0);
		end
		$display("test field_masks done");
		capt();
		apb(0, PRPD_OFF_SEC, 0);
		chk(rd, 32'h0000000f);
		apb(1, PRPD_OFF_NS, 32'h80000000);
		capt();
		foreach (rows[i]) begin
			apb(0, rows[i].a, 0);
			chk(rd, i == 0 ? 32'ha : i == 1 ? 32'h92345678 :
				i == 2 ? 32'h01234567 : 32'h89ab0000);
		end
		ts_enable <= 1;
		apb(1, PRPD_OFF_NS, 0);
		apb(0, PRPD_OFF_NS, 0);
		chk(rd, 32'h80000000);
		ts_enable <= 0;
		$display("test auto_update done");
		@(posedge pclk) drop <= 2'b10;
		repeat (2) @(posedge pclk);
		drop <= 2'b11;
		@(posedge pclk) drop <= 2'b01;
		@(posedge pclk) drop <= 2'b00;
		chk1(mac_rx_error, 1);
		apb(0, PRPD_OFF_UDP_CNT, 0);
		chk1(mac_rx_error, 0);
		chk(rd, 32'h3);
		apb(0, PRPD_OFF_FLT_CNT, 0);
		chk(rd, 32'h2);
		apb(1, PRPD_OFF_UDP_CNT, 0);
		apb(1, PRPD_OFF_FLT_CNT, 32'h5);
		apb(0, PRPD_OFF_UDP_CNT, 0);
		chk(rd, 32'h0);
		apb(0, PRPD_OFF_FLT_CNT, 0);
		chk(rd, 32'h2);
		$display("test drop_tallies done");
		bank_sel <= 3'h2;
		apb(0, PRPD_OFF_SEC, 0);
		chk1(er, 1);
		bank_sel <= 3'h1;
		apb(0, 12'h1a0, 0);
		chk1(er, 1);
		$display("test refusals done");
		// Interrupt: unmasked udp status raises it, a one clears it.
		repeat (2) @(posedge pclk);
		chk1(irq, 0);
		apb(1, PRPD_OFF_IRQ_MSK, 32'h2);
		repeat (2) @(posedge pclk);
		chk1(irq, 1);
		apb(1, PRPD_OFF_IRQ_STS, 32'h2);
		repeat (2) @(posedge pclk);
		chk1(irq, 0);
		$display("test interrupt done");
		// A second reset in mid-run must bring the NS register, auto bit included, back to zero.
		@(posedge pclk) presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, PRPD_OFF_NS, 0);
		chk(rd, PRPD_ZERO);
		$display("test second_reset done");
		summarize();
	end
endmodule // tb_prpd_regs
`default_nettype wire
